// ===== rtl/twb_core.sv
// Two-wire bus controller core: bus error recovery, repeated start, arbitration
// Assumes open-drain SDA/SCL resolved outside and an APB master on clk_sys
`timescale 1ns/1ps
module twb_core
	import twb_pkg::*;
#(
	parameter int HALF_CYC = twb_pkg::SCL_HALF_CYC
) (
	// Clock, reset and clock enable
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic clkEn,
	// APB slave
	input wire twb_pkg::twb_apb_req_type apbReq,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Bus pins, open drain
	input wire twb_pkg::twb_pins_type pinIn,
	output twb_pkg::twb_pins_type pinOut,
	output twb_pkg::twb_pins_type pinOe
);
	import twb_pkg::*;

	localparam twb_regs_type REGS_RST = '{
		state: ST_IDLE,
		status: STAT_NO_INFO,
		buffer: DATA_RST,
		ownAddr: OWN_ADDR_RST,
		sdaPrev: 1'b1,
		sclPrev: 1'b1,
		default: '0
	};

	twb_regs_type r_r;
	twb_regs_type r_nxt;
	twb_pins_type busPin;
	logic evtSet;
	logic [7:0] evtCode;
	logic clrReq;
	logic busStart;
	logic busStop;
	logic sclRise;
	logic sclFall;
	logic halfDone;
	logic masterBits;
	logic txRole;
	logic [7:0] statusRd;

	function automatic logic isMapped(input logic [7:0] addr);
		return addr == ADDR_CTRL || addr == ADDR_STAT || addr == ADDR_DATA || addr == ADDR_OWN;
	endfunction

	twb_sync #(
		.WIDTH(2)
	) u_sync (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.clkEn(clkEn),
		.din(pinIn),
		.q(busPin)
	);

	assign busStart = busPin.scl & r_r.sclPrev & ~busPin.sda & r_r.sdaPrev;
	assign busStop = busPin.scl & r_r.sclPrev & busPin.sda & ~r_r.sdaPrev;
	assign sclRise = busPin.scl & ~r_r.sclPrev;
	assign sclFall = ~busPin.scl & r_r.sclPrev;
	assign halfDone = r_r.timer >= 16'(HALF_CYC - 1);
	assign masterBits = r_r.state == ST_MADDR || r_r.state == ST_MTX || r_r.state == ST_MRX;
	assign txRole = r_r.state == ST_MADDR || r_r.state == ST_MTX || r_r.state == ST_STX;
	assign statusRd = r_r.flag ? r_r.status : STAT_NO_INFO;

	always_comb begin
		r_nxt = r_r;
		evtSet = 1'b0;
		evtCode = r_r.status;
		clrReq = 1'b0;
		r_nxt.sdaPrev = busPin.sda;
		r_nxt.sclPrev = busPin.scl;

		// Register bus; read data is caught in the setup cycle
		if (apbReq.psel && !apbReq.penable) begin
			if (apbReq.paddr == ADDR_CTRL) begin
				r_nxt.prdata = {24'h000000, r_r.flag, r_r.ctrl.ackEn, r_r.ctrl.startReq,
					r_r.ctrl.stopReq, 1'b0, r_r.ctrl.enable, 2'b00};
			end else if (apbReq.paddr == ADDR_STAT) begin
				r_nxt.prdata = {24'h000000, statusRd};
			end else if (apbReq.paddr == ADDR_DATA) begin
				r_nxt.prdata = {24'h000000, r_r.buffer};
			end else if (apbReq.paddr == ADDR_OWN) begin
				r_nxt.prdata = {24'h000000, r_r.ownAddr, 1'b0};
			end else begin
				r_nxt.prdata = '0;
			end
		end
		if (apbReq.psel && apbReq.penable && apbReq.pwrite) begin
			if (apbReq.paddr == ADDR_CTRL) begin
				r_nxt.ctrl.ackEn = apbReq.pwdata[CTRL_ACK_BIT];
				r_nxt.ctrl.startReq = apbReq.pwdata[CTRL_START_BIT];
				r_nxt.ctrl.stopReq = apbReq.pwdata[CTRL_STOP_BIT];
				r_nxt.ctrl.enable = apbReq.pwdata[CTRL_EN_BIT];
				clrReq = apbReq.pwdata[CTRL_FLAG_BIT];
			end else if (apbReq.paddr == ADDR_DATA) begin
				r_nxt.buffer = apbReq.pwdata[7:0];
			end else if (apbReq.paddr == ADDR_OWN) begin
				r_nxt.ownAddr = apbReq.pwdata[OWN_ADDR_LSB+:7];
			end
		end

		// Master clock: low half, release, then high half counted only once SCL is
		// really high, so a stretching slave or a slower master simply pauses us
		if (masterBits && !r_r.flag) begin
			if (r_r.sclLow) begin
				r_nxt.timer = halfDone ? 16'h0000 : r_r.timer + 16'h0001;
				r_nxt.sclLow = ~halfDone;
			end else if (busPin.scl) begin
				r_nxt.timer = halfDone ? 16'h0000 : r_r.timer + 16'h0001;
				r_nxt.sclLow = halfDone;
			end
		end

		// START, repeated START and STOP generation
		if (r_r.state == ST_GEN) begin
			r_nxt.timer = r_r.timer + 16'h0001;
			case (r_r.step)
				2'd0: begin
					r_nxt.sdaLow = r_r.isStop;
					if (halfDone) begin
						r_nxt.step = 2'd1;
						r_nxt.timer = '0;
					end
				end
				2'd1: begin
					r_nxt.sclLow = 1'b0;
					if (!busPin.scl) begin
						r_nxt.timer = '0;
					end else if (halfDone) begin
						r_nxt.step = 2'd2;
						r_nxt.timer = '0;
					end
				end
				2'd2: begin
					r_nxt.sdaLow = ~r_r.isStop;
					if (halfDone) begin
						r_nxt.timer = '0;
						r_nxt.step = 2'd3;
						if (r_r.isStop) begin
							r_nxt.state = ST_IDLE;
							r_nxt.ctrl.stopReq = 1'b0;
						end
					end
				end
				default: begin
					r_nxt.sclLow = 1'b1;
					r_nxt.state = ST_MADDR;
					r_nxt.txShift = r_r.buffer;
					evtSet = 1'b1;
					evtCode = r_r.repStart ? STAT_REP_START : STAT_START;
				end
			endcase
		end else if (r_r.state == ST_IDLE && r_r.ctrl.startReq && !r_r.busy && !r_r.flag) begin
			r_nxt.state = ST_GEN;
			r_nxt.isStop = 1'b0;
			r_nxt.repStart = 1'b0;
			r_nxt.step = 2'd0;
			r_nxt.timer = '0;
		end

		// Bus monitor and byte engine
		if (busStart || busStop) begin
			r_nxt.busy = busStart;
			r_nxt.firstByte = busStart;
			r_nxt.bitCnt = '0;
			r_nxt.arbLostAddr = 1'b0;
			// A condition after the second clock of a byte or during the ack is misplaced
			if (r_r.busy && r_r.bitCnt > 4'd1 && r_r.state != ST_BERR) begin
				r_nxt.state = ST_BERR;
				r_nxt.sdaLow = 1'b0;
				r_nxt.sclLow = 1'b0;
				evtSet = 1'b1;
				evtCode = STAT_BUS_ERR;
			end else if (r_r.state == ST_SRX || r_r.state == ST_STX) begin
				r_nxt.state = ST_IDLE;
				r_nxt.sdaLow = 1'b0;
				evtSet = 1'b1;
				evtCode = STAT_SLV_STOP;
			end
		end else if (sclRise) begin
			if (r_r.bitCnt != 4'd9) begin
				r_nxt.bitCnt = r_r.bitCnt + 4'd1;
			end
			if (r_r.bitCnt < 4'd8) begin
				r_nxt.rxShift = {r_r.rxShift[6:0], busPin.sda};
			end else if (r_r.bitCnt == 4'd8) begin
				r_nxt.ackSeen = ~busPin.sda;
			end
			// Only a mismatch is seen, so identical traffic passes unnoticed
			if (r_r.bitCnt < 4'd8 && (r_r.state == ST_MADDR || r_r.state == ST_MTX)
				&& !r_r.sdaLow && !busPin.sda) begin
				r_nxt.state = ST_IDLE;
				r_nxt.sdaLow = 1'b0;
				r_nxt.sclLow = 1'b0;
				if (r_r.state == ST_MADDR) begin
					r_nxt.arbLostAddr = 1'b1;
				end else begin
					evtSet = 1'b1;
					evtCode = STAT_ARB_LOST;
				end
			end
		end else if (sclFall) begin
			if (r_r.bitCnt == 4'd0 && txRole) begin
				r_nxt.sdaLow = ~r_r.txShift[7];
			end else if (r_r.bitCnt < 4'd8 && txRole) begin
				r_nxt.txShift = {r_r.txShift[6:0], 1'b0};
				r_nxt.sdaLow = ~r_r.txShift[6];
			end else if (r_r.bitCnt == 4'd8) begin
				if (r_r.state == ST_IDLE && r_r.firstByte) begin
					r_nxt.addrHit = r_r.rxShift[7:1] == r_r.ownAddr && r_r.ctrl.ackEn;
					r_nxt.sdaLow = r_r.rxShift[7:1] == r_r.ownAddr && r_r.ctrl.ackEn;
				end else begin
					r_nxt.sdaLow = (r_r.state == ST_MRX || r_r.state == ST_SRX) && r_r.ctrl.ackEn;
				end
			end else if (r_r.bitCnt == 4'd9) begin
				r_nxt.bitCnt = '0;
				r_nxt.firstByte = 1'b0;
				r_nxt.arbLostAddr = 1'b0;
				r_nxt.sdaLow = 1'b0;
				evtSet = 1'b1;
				case (r_r.state)
					ST_MADDR: begin
						r_nxt.state = r_r.rxShift[0] ? ST_MRX : ST_MTX;
						evtCode = r_r.rxShift[0]
							? (r_r.ackSeen ? STAT_SLA_R_ACK : STAT_SLA_R_NACK)
							: (r_r.ackSeen ? STAT_SLA_W_ACK : STAT_SLA_W_NACK);
					end
					ST_MTX: evtCode = r_r.ackSeen ? STAT_TX_ACK : STAT_TX_NACK;
					ST_MRX: evtCode = r_r.ackSeen ? STAT_RX_ACK : STAT_RX_NACK;
					ST_SRX: begin
						evtCode = r_r.ackSeen ? STAT_SRX_ACK : STAT_SRX_NACK;
						r_nxt.state = r_r.ackSeen ? ST_SRX : ST_IDLE;
					end
					ST_STX: begin
						evtCode = r_r.ackSeen ? STAT_STX_ACK : STAT_STX_NACK;
						r_nxt.state = r_r.ackSeen ? ST_STX : ST_IDLE;
					end
					ST_IDLE: begin
						if (r_r.firstByte && r_r.addrHit) begin
							r_nxt.state = r_r.rxShift[0] ? ST_STX : ST_SRX;
							evtCode = r_r.rxShift[0]
								? (r_r.arbLostAddr ? STAT_ARB_OWN_R : STAT_OWN_R)
								: (r_r.arbLostAddr ? STAT_ARB_OWN_W : STAT_OWN_W);
						end else if (r_r.firstByte && r_r.arbLostAddr) begin
							evtCode = STAT_ARB_LOST;
						end else begin
							evtSet = 1'b0;
						end
					end
					default: evtSet = 1'b0;
				endcase
				r_nxt.addrHit = 1'b0;
				// The last byte on the bus is kept with each event at the end of a byte, so an arbitration lost in the address byte keeps it
				if (evtSet) begin
					r_nxt.buffer = r_r.rxShift;
				end
			end
		end

		// Software answer; a flag set in the same cycle wins and the answer is dropped
		if (clrReq && r_r.flag && !evtSet) begin
			r_nxt.flag = 1'b0;
			if (r_r.state == ST_MADDR || masterBits) begin
				if (r_nxt.ctrl.stopReq || r_nxt.ctrl.startReq) begin
					// Repeated START sends no STOP and ends with SCL held low, so the bus is never let go
					r_nxt.state = ST_GEN;
					r_nxt.isStop = r_nxt.ctrl.stopReq;
					r_nxt.repStart = 1'b1;
					r_nxt.step = 2'd0;
					r_nxt.timer = '0;
				end else if (txRole) begin
					r_nxt.txShift = r_r.buffer;
					r_nxt.sdaLow = ~r_r.buffer[7];
				end
			end else if (r_r.state == ST_STX && !r_nxt.ctrl.stopReq) begin
				r_nxt.txShift = r_r.buffer;
				r_nxt.sdaLow = ~r_r.buffer[7];
			end else if (r_nxt.ctrl.stopReq) begin
				r_nxt.state = ST_IDLE;
				r_nxt.ctrl.stopReq = 1'b0;
				r_nxt.sdaLow = 1'b0;
				r_nxt.sclLow = 1'b0;
			end
		end
		if (evtSet) begin
			r_nxt.flag = 1'b1;
			r_nxt.status = evtCode;
		end

		// Disabled: all transfers end at once and both lines are released
		if (!r_r.ctrl.enable) begin
			r_nxt.state = ST_IDLE;
			r_nxt.sdaLow = 1'b0;
			r_nxt.sclLow = 1'b0;
			r_nxt.flag = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			r_r <= REGS_RST;
		end else if (clkEn) begin
			r_r <= r_nxt;
		end
	end

	assign prdata = r_r.prdata;
	assign pready = clkEn;
	assign pslverr = apbReq.psel & apbReq.penable & ~isMapped(apbReq.paddr);
	assign pinOut = '0;
	assign pinOe.sda = r_r.sdaLow;
	// An addressed slave holds SCL low while software answers
	assign pinOe.scl = r_r.sclLow | (r_r.flag & (r_r.state == ST_SRX || r_r.state == ST_STX));
endmodule

// ===== rtl/twb_pkg.sv
// Shared constants and types for the two-wire bus error and arbitration block
// Assumes a 25 MHz system clock and an APB slave port with 32-bit data
package twb_pkg;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STAT = 8'h04;
	localparam logic [7:0] ADDR_DATA = 8'h08;
	localparam logic [7:0] ADDR_OWN = 8'h0C;
	localparam int CTRL_FLAG_BIT = 7;
	localparam int CTRL_ACK_BIT = 6;
	localparam int CTRL_START_BIT = 5;
	localparam int CTRL_STOP_BIT = 4;
	localparam int CTRL_EN_BIT = 2;
	localparam int OWN_ADDR_LSB = 1;
	localparam logic [6:0] OWN_ADDR_RST = 7'h7F;
	localparam logic [7:0] DATA_RST = 8'hFF;
	localparam int CLK_PERIOD_NS = 40;
	localparam int SCL_HALF_NS = 5000;
	localparam int SCL_HALF_CYC = (SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] STAT_NO_INFO = 8'hF8;
	localparam logic [7:0] STAT_BUS_ERR = 8'h00;
	localparam logic [7:0] STAT_START = 8'h08;
	localparam logic [7:0] STAT_REP_START = 8'h10;
	localparam logic [7:0] STAT_SLA_W_ACK = 8'h18;
	localparam logic [7:0] STAT_SLA_W_NACK = 8'h20;
	localparam logic [7:0] STAT_TX_ACK = 8'h28;
	localparam logic [7:0] STAT_TX_NACK = 8'h30;
	localparam logic [7:0] STAT_ARB_LOST = 8'h38;
	localparam logic [7:0] STAT_SLA_R_ACK = 8'h40;
	localparam logic [7:0] STAT_SLA_R_NACK = 8'h48;
	localparam logic [7:0] STAT_RX_ACK = 8'h50;
	localparam logic [7:0] STAT_RX_NACK = 8'h58;
	localparam logic [7:0] STAT_OWN_W = 8'h60;
	localparam logic [7:0] STAT_ARB_OWN_W = 8'h68;
	localparam logic [7:0] STAT_SRX_ACK = 8'h80;
	localparam logic [7:0] STAT_SRX_NACK = 8'h88;
	localparam logic [7:0] STAT_SLV_STOP = 8'hA0;
	localparam logic [7:0] STAT_OWN_R = 8'hA8;
	localparam logic [7:0] STAT_ARB_OWN_R = 8'hB0;
	localparam logic [7:0] STAT_STX_ACK = 8'hB8;
	localparam logic [7:0] STAT_STX_NACK = 8'hC0;

	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_BERR = 8'h02,
		ST_GEN = 8'h04,
		ST_MADDR = 8'h08,
		ST_MTX = 8'h10,
		ST_MRX = 8'h20,
		ST_SRX = 8'h40,
		ST_STX = 8'h80
	} twb_state_type;

	typedef struct packed {
		logic sda;
		logic scl;
	} twb_pins_type;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} twb_apb_req_type;

	typedef struct packed {
		logic ackEn;
		logic startReq;
		logic stopReq;
		logic enable;
	} twb_ctrl_type;

	typedef struct packed {
		twb_state_type state;
		twb_ctrl_type ctrl;
		logic flag;
		logic [7:0] status;
		logic [7:0] buffer;
		logic [6:0] ownAddr;
		logic [7:0] txShift;
		logic [7:0] rxShift;
		logic [3:0] bitCnt;
		logic busy;
		logic firstByte;
		logic arbLostAddr;
		logic addrHit;
		logic ackSeen;
		logic isStop;
		logic repStart;
		logic [1:0] step;
		logic [15:0] timer;
		logic sdaLow;
		logic sclLow;
		logic sdaPrev;
		logic sclPrev;
		logic [31:0] prdata;
	} twb_regs_type;
endpackage

// ===== rtl/twb_sync.sv
// Two-stage synchroniser for pin levels entering the system clock domain
// Assumes inputs are asynchronous to clk_sys; only the second stage is read outside
`timescale 1ns/1ps
module twb_sync #(
	parameter int WIDTH = 2
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic clkEn,
	// Levels
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] q
);
	logic [1:0][WIDTH-1:0] stage_r;
	logic [1:0][WIDTH-1:0] stage_nxt;

	always_comb begin
		stage_nxt = {stage_r[0], din};
	end

	// Idle bus lines are high, so reset to ones to avoid a false edge at release
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			stage_r <= '1;
		end else if (clkEn) begin
			stage_r <= stage_nxt;
		end
	end

	assign q = stage_r[1];
endmodule

// ===== verification/tb.sv
// Testbench for twb_core: APB sequences against the bus model
// Assumes the core, the bus model and the bound checker are compiled
`timescale 1ns/1ps
module tb;
	import twb_pkg::*;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	twb_apb_req_type apbReq = '0;
	logic [31:0] prdata, q, v;
	logic pready, pslverr, e;
	twb_pins_type pinIn, pinOe;
	logic ackOn = 1'b0;
	logic slow = 1'b0;
	logic errGo = 1'b0;
	logic arbHold = 1'b0;
	int errors = 0;
	int checkCount = 0;
	int cyc = 0;
	int n;
	always #20 clk_sys = ~clk_sys;
	twb_core #(.HALF_CYC(4)) twb_core_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.clkEn(1'b1), .apbReq(apbReq), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pinIn(pinIn), .pinOut(), .pinOe(pinOe));
	twb_bus_model twb_bus_model_inst (.pinOe(pinOe), .pinIn(pinIn), .ackOn(ackOn),
		.slow(slow), .errGo(errGo), .arbHold(arbHold));
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checkCount, errors);
		if (errors == 0 && checkCount > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 30000) begin
			errors++;
			report_and_stop();
		end
	end
	task automatic chk(input string w, input logic [31:0] x, input logic [31:0] got);
		checkCount++;
		if (got !== x) begin
			errors++;
			$display("ERROR %s expected %h seen %h", w, x, got);
		end
	endtask
	// Request stands until pready is seen high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		apbReq <= '{1'b1, 1'b0, wr, a, d};
		@(posedge clk_sys);
		apbReq.penable <= 1'b1;
		// Only the bench timeout ends a wait for pready
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		apbReq <= '0;
		@(posedge clk_sys);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] x, input string w);
		apb(1'b0, a, '0);
		chk(w, x, q);
	endtask
	task automatic poll();
		int k;
		k = 0;
		do begin
			apb(1'b0, ADDR_STAT, '0);
			k++;
		end while (q[7:0] === STAT_NO_INFO && k < 300);
	endtask
	task automatic step(input logic [31:0] c, input logic [7:0] s);
		apb(1'b1, ADDR_CTRL, c);
		poll();
		chk("status", {24'h0, s}, q);
	endtask
	initial begin
		repeat (12) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		rchk(ADDR_CTRL, 32'h0, "ctrl");
		rchk(ADDR_STAT, {24'h0, STAT_NO_INFO}, "stat");
		rchk(ADDR_DATA, {24'h0, DATA_RST}, "data");
		rchk(ADDR_OWN, {24'h0, OWN_ADDR_RST, 1'b0}, "own");
		apb(1'b1, ADDR_STAT, 32'h0);
		rchk(ADDR_STAT, {24'h0, STAT_NO_INFO}, "stat read-only");
		apb(1'b0, 8'h10, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, q);
		$display("test registers done");
		for (int k = 0; k < 2; k++) begin
			v = {25'h0, k[0], 6'h04};
			apb(1'b1, ADDR_CTRL, v);
			errGo <= 1'b1;
			poll();
			errGo <= 1'b0;
			chk("error status", {24'h0, STAT_BUS_ERR}, q);
			rchk(ADDR_CTRL, v | 32'h80, "flag");
			chk("lines released", 32'h0, {30'h0, pinOe});
			apb(1'b1, ADDR_CTRL, v | 32'h90);
			rchk(ADDR_CTRL, v, "ctrl after recovery");
			rchk(ADDR_STAT, {24'h0, STAT_NO_INFO}, "stat after recovery");
			chk("no stop driven", 32'h0, {30'h0, pinOe});
		end
		$display("test bus error done");
		ackOn <= 1'b1;
		apb(1'b1, ADDR_DATA, 32'hA0);
		step(32'h24, STAT_START);
		step(32'h84, STAT_SLA_W_ACK);
		apb(1'b1, ADDR_DATA, 32'h10);
		slow <= 1'b1;
		step(32'h84, STAT_TX_ACK);
		apb(1'b1, ADDR_DATA, 32'hA1);
		step(32'hA4, STAT_REP_START);
		chk("bus held", 32'h1, {31'h0, pinOe.scl});
		step(32'h84, STAT_SLA_R_ACK);
		apb(1'b1, ADDR_CTRL, 32'h94);
		n = 0;
		do begin
			apb(1'b0, ADDR_CTRL, 32'h0);
			n++;
		end while (q[4] !== 1'b0 && n < 100);
		chk("stop done", 32'h04, q);
		rchk(ADDR_STAT, {24'h0, STAT_NO_INFO}, "idle stat");
		$display("test repeated start done");
		apb(1'b1, ADDR_DATA, 32'hA0);
		step(32'h24, STAT_START);
		step(32'h84, STAT_SLA_W_ACK);
		apb(1'b1, ADDR_DATA, 32'hFF);
		arbHold <= 1'b1;
		step(32'h84, STAT_ARB_LOST);
		chk("loser released", 32'h0, {30'h0, pinOe});
		arbHold <= 1'b0;
		apb(1'b1, ADDR_CTRL, 32'h84);
		rchk(ADDR_STAT, {24'h0, STAT_NO_INFO}, "stat after loss");
		rchk(ADDR_CTRL, 32'h04, "unaddressed slave");
		$display("test arbitration done");
		report_and_stop();
	end
endmodule

// ===== verification/twb_bus_model.sv
// Far side of the bus: an acking slave and a master that breaks a frame
// Assumes pull-ups on both lines and a link clock of 320 ns period
`timescale 1ns/1ps
module twb_bus_model
	import twb_pkg::*;
(
	// Design pins
	input wire twb_pkg::twb_pins_type pinOe,
	output twb_pkg::twb_pins_type pinIn,
	// Bench control
	input wire logic ackOn,
	input wire logic slow,
	input wire logic errGo,
	input wire logic arbHold
);
	logic sdaLow = 1'b0;
	logic sclLow = 1'b0;
	int cnt = 0;
	// Released lines float high through the pull-ups
	// A rival master holding SDA low beats any released data bit
	assign pinIn = {!(pinOe.sda || sdaLow || arbHold), !(pinOe.scl || sclLow)};
	always @(negedge pinIn.sda) begin
		if (pinIn.scl) cnt = 0;
	end
	// A slow slave stretches SCL at the ack, so the master must wait for it
	always @(negedge pinIn.scl) begin
		cnt = cnt + 1;
		if (ackOn && cnt == 9) begin
			sdaLow = 1'b1;
			if (slow) begin
				sclLow = 1'b1;
				#800 sclLow = 1'b0;
			end
		end
		if (ackOn && cnt == 10) begin
			sdaLow = 1'b0;
			cnt = 1;
		end
	end
	// STOP inside the first byte of a frame
	always @(posedge errGo) begin
		sdaLow = 1'b1;
		#160 sclLow = 1'b1;
		repeat (3) begin
			#160 sclLow = 1'b0;
			#160 sclLow = 1'b1;
		end
		#160 sclLow = 1'b0;
		#160 sdaLow = 1'b0;
	end
endmodule

// ===== verification/twb_core_assertions.sv
// Port checker for twb_core: register bus, error recovery, pin release
// Assumes one clock domain on clk_sys with sys_rst as its reset
`timescale 1ns/1ps
module twb_core_assertions
	import twb_pkg::*;
#(
	parameter int HALF_CYC = 4
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic clkEn,
	// Register bus
	input wire twb_pkg::twb_apb_req_type apbReq,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Pins
	input wire twb_pkg::twb_pins_type pinIn,
	input wire twb_pkg::twb_pins_type pinOut,
	input wire twb_pkg::twb_pins_type pinOe
);
	logic acc, badAddr, rdStat, rdCtrl, ctrlWr, recovWr;
	logic errPend_r, recov_r;
	assign acc = apbReq.psel && apbReq.penable && pready;
	assign badAddr = !(apbReq.paddr inside {ADDR_CTRL, ADDR_STAT, ADDR_DATA, ADDR_OWN});
	assign rdStat = acc && !apbReq.pwrite && apbReq.paddr == ADDR_STAT;
	assign rdCtrl = acc && !apbReq.pwrite && apbReq.paddr == ADDR_CTRL;
	assign ctrlWr = acc && apbReq.pwrite && apbReq.paddr == ADDR_CTRL;
	// Ack bit is left out of the match: recovery accepts either value
	assign recovWr = ctrlWr && errPend_r && (apbReq.pwdata & 32'hB4) == 32'h94;
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			errPend_r <= 1'b0;
			recov_r <= 1'b0;
		end else begin
			errPend_r <= (errPend_r && !ctrlWr) || (rdStat && prdata[7:0] == STAT_BUS_ERR);
			recov_r <= recovWr || (recov_r && !(acc && apbReq.pwrite));
		end
	end
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);
	ready_data_a: assert property (apbReq.psel && apbReq.penable && clkEn
		|-> pready && prdata[31:8] == '0) else $error("access not ready");
	unmapped_err_a: assert property (apbReq.psel && apbReq.penable |-> pslverr == badAddr)
		else $error("wrong slave error");
	unmapped_zero_a: assert property (acc && badAddr && !apbReq.pwrite |-> prdata == '0)
		else $error("unmapped read not zero");
	open_drain_a: assert property (pinOut == '0) else $error("pin driven high");
	err_release_a: assert property (rdStat && prdata[7:0] == STAT_BUS_ERR |-> pinOe == '0)
		else $error("lines held in bus error");
	err_hold_a: assert property (errPend_r && rdStat |-> prdata[7:0] == STAT_BUS_ERR)
		else $error("bus error status lost");
	recov_quiet_a: assert property (recovWr |=> (pinOe == '0) [*8])
		else $error("line driven after recovery");
	recov_ctrl_a: assert property (recov_r && rdCtrl |-> prdata[7] == 1'b0 && !prdata[4])
		else $error("flag or stop bit left set");
	recov_stat_a: assert property (recov_r && rdStat |-> prdata[7:0] == STAT_NO_INFO)
		else $error("status not idle after recovery");
	rstart_own_a: assert property (rdStat && prdata[7:0] == STAT_REP_START |-> pinOe.scl)
		else $error("bus let go after repeated start");
	cover property (rdStat && prdata[7:0] == STAT_BUS_ERR);
	cover property (recovWr);
	arb_release_a: assert property (rdStat && prdata[7:0] == STAT_ARB_LOST |-> pinOe == '0)
		else $error("loser still drives the bus");
	cover property (rdStat && prdata[7:0] == STAT_REP_START);
	cover property (rdStat && prdata[7:0] == STAT_ARB_LOST);
endmodule
bind twb_core twb_core_assertions #(.HALF_CYC(HALF_CYC)) twb_core_assertions_inst (
	.clk_sys(clk_sys), .sys_rst(sys_rst), .clkEn(clkEn), .apbReq(apbReq), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe));
